// file: internal_periph_bus_decoder_pkg.sv
// Package: address map, enable bit positions, reset values and access timing
package internal_periph_bus_decoder_pkg;

   // -----------------------------------------------------------------
   // Address map
   // -----------------------------------------------------------------
   localparam int unsigned  ADDR_W          = 24;
   localparam logic [23:0]  SMALL_RAM_LO    = 24'h00e000;
   localparam logic [23:0]  SMALL_RAM_HI    = 24'h00e7ff;
   localparam logic [23:0]  LARGE_RAM_LO    = 24'h00c000;
   localparam logic [23:0]  LARGE_RAM_HI    = 24'h00dfff;
   localparam logic [23:0]  FIRST_CAN_MODULE_LO         = 24'h00ef00;
   localparam logic [23:0]  FIRST_CAN_MODULE_HI         = 24'h00efff;
   localparam logic [23:0]  SECOND_CAN_MODULE_LO         = 24'h00ee00;
   localparam logic [23:0]  SECOND_CAN_MODULE_HI         = 24'h00eeff;
   localparam logic [23:0]  FUNC_AREA_LO    = 24'h00f000;
   localparam logic [23:0]  FUNC_AREA_HI    = 24'h00ffff;
   localparam logic [23:0]  EXT_FUNC_LO     = 24'h00f000;
   localparam logic [23:0]  EXT_FUNC_HI     = 24'h00f1ff;
   localparam logic [23:0]  STD_FUNC_LO     = 24'h00fe00;
   localparam logic [23:0]  STD_FUNC_HI     = 24'h00ffff;
   localparam logic [23:0]  INTERNAL_DUAL_PORT_RAM_LO         = 24'h00f600;
   localparam logic [23:0]  INTERNAL_DUAL_PORT_RAM_HI         = 24'h00fdff;
   localparam int unsigned  SMALL_RAM_BYTES = 2048;
   localparam int unsigned  LARGE_RAM_BYTES = 8192;
   localparam int unsigned  INTERNAL_DUAL_PORT_RAM_BYTES      = 2048;
   localparam int unsigned  FUNC_AREA_BYTES = 512;
   localparam int unsigned  SEG_LINES_CAN   = 4;

   // -----------------------------------------------------------------
   // Register map (AXI4-Lite byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0]   SYSCFG_OFS      = 8'h00;
   localparam logic [7:0]   PERCFG_OFS      = 8'h04;
   localparam logic [7:0]   STATUS_OFS      = 8'h08;
   localparam int unsigned  GLOBAL_EN_BIT   = 2;
   localparam int unsigned  FIRST_CAN_MODULE_EN_BIT     = 0;
   localparam int unsigned  SECOND_CAN_MODULE_EN_BIT     = 1;
   localparam int unsigned  SMALL_EN_BIT    = 2;
   localparam int unsigned  LARGE_EN_BIT    = 3;
   localparam logic [7:0]   PERCFG_RESET    = 8'h05;
   localparam logic [7:0]   SYSCFG_RESET    = 8'h00;
   localparam logic [1:0]   RESP_OKAY       = 2'b00;
   localparam logic [1:0]   RESP_SLVERR     = 2'b10;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned  CLK_PERIOD_PS   = 20000;
   localparam int unsigned  EXTENSION_RAM_ACCESS_PS  = 62500;
   localparam int unsigned  CAN_ACCESS_PS   = 125000;
   localparam int unsigned  CPU_CYCLE_PS    = 62500;
   // Fast RAM: one bus cycle, no wait state
   localparam int unsigned  EXTENSION_RAM_WAITS      = 0;
   // CAN: two wait states beyond the base cycle
   localparam int unsigned  CAN_WAITS       = 2;

   typedef enum logic [2:0] {
      TGT_EXT, TGT_SMALL_RAM, TGT_LARGE_RAM, TGT_FIRST_CAN_MODULE, TGT_SECOND_CAN_MODULE, TGT_FUNC, TGT_INTERNAL_DUAL_PORT_RAM
   } target_t;

   typedef struct packed {
      logic [23:0] addr;
      logic        write;
      logic [1:0]  byte_en;
      logic [15:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic        global_en;
      logic        small_en;
      logic        large_en;
      logic        first_can_module_en;
      logic        second_can_module_en;
   } enables_t;

endpackage

// file: internal_periph_bus_target_decode.sv
// Combinational address-to-target decode with enable gating
module internal_periph_bus_target_decode
   import internal_periph_bus_decoder_pkg::*;
(
   input  wire logic [23:0] addr,
   input  wire enables_t    en,
   output target_t          target,
   output logic [4:0]       wait_states
);
   wire in_small = addr >= SMALL_RAM_LO && addr <= SMALL_RAM_HI;
   wire in_large = addr >= LARGE_RAM_LO && addr <= LARGE_RAM_HI;
   wire in_first_can_module  = addr >= FIRST_CAN_MODULE_LO && addr <= FIRST_CAN_MODULE_HI;
   wire in_second_can_module  = addr >= SECOND_CAN_MODULE_LO && addr <= SECOND_CAN_MODULE_HI;
   wire in_internal_dual_port_ram  = addr >= INTERNAL_DUAL_PORT_RAM_LO && addr <= INTERNAL_DUAL_PORT_RAM_HI;
   wire in_ext_f = addr >= EXT_FUNC_LO && addr <= EXT_FUNC_HI;
   wire in_std_f = addr >= STD_FUNC_LO && addr <= STD_FUNC_HI;

   // Disabled areas fall to the external interface
   assign target = (in_std_f | in_ext_f)                 ? TGT_FUNC      :
                   in_internal_dual_port_ram                               ? TGT_INTERNAL_DUAL_PORT_RAM      :
                   (in_small & en.global_en & en.small_en) ? TGT_SMALL_RAM :
                   (in_large & en.global_en & en.large_en) ? TGT_LARGE_RAM :
                   (in_first_can_module & en.global_en & en.first_can_module_en) ? TGT_FIRST_CAN_MODULE      :
                   (in_second_can_module & en.global_en & en.second_can_module_en) ? TGT_SECOND_CAN_MODULE      :
                   TGT_EXT;

   assign wait_states = (target == TGT_FIRST_CAN_MODULE || target == TGT_SECOND_CAN_MODULE) ? 5'(CAN_WAITS)
                                                                    : 5'(EXTENSION_RAM_WAITS);
endmodule

// file: internal_periph_bus_address_decoder.sv
// Top: address decoder with AXI4-Lite configuration registers and CPU access path
//
// Operation
// - Flat 16M-byte space, every location reachable by byte or word access.
// - Internal dual-port RAM of 2K holds 16-word register banks.
// - Extension RAM is 10K: small 2K area plus large 8K area.
// - Extension RAM access: 16-bit, no wait state, byte or word.
// - E000-E7FF goes to small RAM when global and small enables set.
// - Otherwise small RAM range goes to external interface.
// - C000-DFFF goes to large RAM when global and large enables set.
// - Otherwise large RAM range goes to external interface.
// - 1024 bytes in two 512-byte areas reserved for function registers.
// - EF00-EFFF reaches first CAN when global and first-CAN enables set.
// - EE00-EEFF reaches second CAN when global and second-CAN enables set.
// - CAN access: 16-bit demultiplexed, byte allowed, two wait states.
// - With any CAN used only four segment address lines drive out.
// - Both CANs disabled: EE00-EFFF goes to external interface.
// - Peripheral config resets to 05h: first CAN and small RAM on.
// - Peripheral config is locked while global enable is set.
module internal_periph_bus_address_decoder
   import internal_periph_bus_decoder_pkg::*;
#(
   parameter int unsigned MAX_WAITS = 7
)(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // CPU side
   input  wire cpu_req_t    cpu_req,
   input  wire logic        cpu_req_valid,
   output logic             cpu_ready,
   // Target side
   output cpu_req_t         tgt_req,
   output logic [6:0]       tgt_sel,
   output logic             seg_limit
);

   if (MAX_WAITS < CAN_WAITS || MAX_WAITS > 31) begin : g_bad_waits
      $error("MAX_WAITS out of range");
   end

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   logic [7:0] syscfg_q;
   logic [7:0] percfg_q;
   logic       aw_got_q;
   logic       w_got_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   wire global_en   = syscfg_q[GLOBAL_EN_BIT];
   wire aw_take     = s_axi_awvalid & s_axi_awready;
   wire w_take      = s_axi_wvalid & s_axi_wready;
   wire wr_go       = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire wr_sys      = wr_go & (awaddr_q == SYSCFG_OFS);
   wire wr_per      = wr_go & (awaddr_q == PERCFG_OFS);
   wire wr_known    = wr_sys | wr_per | (awaddr_q == STATUS_OFS);
   wire per_write   = wr_per & wstrb_q[0] & ~global_en;
   wire sys_write   = wr_sys & wstrb_q[0];

   enables_t en;
   assign en.global_en = global_en;
   assign en.small_en  = percfg_q[SMALL_EN_BIT];
   assign en.large_en  = percfg_q[LARGE_EN_BIT];
   assign en.first_can_module_en   = percfg_q[FIRST_CAN_MODULE_EN_BIT];
   assign en.second_can_module_en   = percfg_q[SECOND_CAN_MODULE_EN_BIT];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syscfg_q      <= SYSCFG_RESET;
         percfg_q      <= PERCFG_RESET;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (aw_take) begin
            aw_got_q      <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_got_q      <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (sys_write)
            syscfg_q <= wdata_q[7:0];
         if (per_write)
            percfg_q <= wdata_q[7:0];
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Register reads
   // -----------------------------------------------------------------
   logic [31:0] rd_val;
   logic [1:0]  rd_resp;
   wire  [7:0]  status_val = {2'b00, seg_limit, tgt_sel[4:0]};

   assign rd_val  = (s_axi_araddr == SYSCFG_OFS) ? {24'h000000, syscfg_q} :
                    (s_axi_araddr == PERCFG_OFS) ? {24'h000000, percfg_q} :
                    (s_axi_araddr == STATUS_OFS) ? {24'h000000, status_val} :
                    32'h00000000;
   assign rd_resp = (s_axi_araddr == SYSCFG_OFS || s_axi_araddr == PERCFG_OFS ||
                     s_axi_araddr == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_resp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // CPU access path
   // -----------------------------------------------------------------
   // Decode is registered at request time so enables changing mid-access
   // cannot move the access to another target.
   typedef enum {ST_IDLE, ST_WAIT} acc_state_t;
   acc_state_t  state_q;
   logic [4:0]  wait_q;
   target_t     dec_target;
   logic [4:0]  dec_waits;
   logic [6:0]  sel_d;

   internal_periph_bus_target_decode u_decode (
      .addr        (cpu_req.addr),
      .en          (en),
      .target      (dec_target),
      .wait_states (dec_waits)
   );

   // One-hot select, one bit per target
   generate
      for (genvar i = 0; i < 7; i++) begin : g_sel
         assign sel_d[i] = (dec_target == target_t'(i));
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q   <= ST_IDLE;
         wait_q    <= 5'h00;
         tgt_req   <= '0;
         tgt_sel   <= 7'h00;
         cpu_ready <= 1'b0;
         seg_limit <= 1'b0;
      end else if (clk_en) begin
         seg_limit <= global_en & (en.first_can_module_en | en.second_can_module_en);
         cpu_ready <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // The request still stands at its ready edge: do not take it twice
               if (cpu_req_valid && !cpu_ready) begin
                  tgt_req <= cpu_req;
                  tgt_sel <= sel_d;
                  wait_q  <= dec_waits;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (wait_q == 5'h00) begin
                  cpu_ready <= 1'b1;
                  tgt_sel   <= 7'h00;
                  state_q   <= ST_IDLE;
               end else begin
                  wait_q <= wait_q - 5'h01;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence can_access_s;
      state_q == ST_IDLE && cpu_req_valid && !cpu_ready && clk_en &&
      (dec_target == TGT_FIRST_CAN_MODULE || dec_target == TGT_SECOND_CAN_MODULE);
   endsequence

   onehot_select_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_WAIT) |-> $onehot(tgt_sel))
      else $error("target select not one-hot");

   can_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
      can_access_s ##1 clk_en [*4] |-> cpu_ready)
      else $error("CAN access not four cycles");

   extension_ram_fast_a: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == ST_IDLE && cpu_req_valid && !cpu_ready && clk_en &&
       dec_target == TGT_SMALL_RAM) ##1 clk_en [*2] |-> cpu_ready)
      else $error("ext RAM access not zero wait");

   small_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (dec_target == TGT_SMALL_RAM) |-> (en.global_en && en.small_en))
      else $error("small RAM selected while disabled");

   large_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cpu_req.addr >= LARGE_RAM_LO && cpu_req.addr <= LARGE_RAM_HI &&
       !(en.global_en && en.large_en)) |-> dec_target == TGT_EXT)
      else $error("disabled large RAM not external");

   can_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cpu_req.addr >= SECOND_CAN_MODULE_LO && cpu_req.addr <= FIRST_CAN_MODULE_HI &&
       !en.first_can_module_en && !en.second_can_module_en) |-> dec_target == TGT_EXT)
      else $error("CAN range not external");

   percfg_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
      (global_en && clk_en) |=> $stable(percfg_q))
      else $error("peripheral config changed after lock");

   seg_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
      (clk_en && global_en && (en.first_can_module_en || en.second_can_module_en)) |=> seg_limit)
      else $error("segment limit missing with CAN");

   axi_resp_a: assert property (@(posedge clk_sys) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && clk_en) |=> s_axi_rvalid)
      else $error("read answer late");

   large_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (dec_target == TGT_LARGE_RAM) |-> (en.global_en && en.large_en))
      else $error("large RAM selected while disabled");

   small_route_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cpu_req.addr >= SMALL_RAM_LO && cpu_req.addr <= SMALL_RAM_HI &&
       !(en.global_en && en.small_en)) |-> dec_target == TGT_EXT)
      else $error("disabled small RAM not external");

   first_can_module_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (dec_target == TGT_FIRST_CAN_MODULE) |-> (en.global_en && en.first_can_module_en))
      else $error("first CAN selected while disabled");

   second_can_module_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      (dec_target == TGT_SECOND_CAN_MODULE) |-> (en.global_en && en.second_can_module_en))
      else $error("second CAN selected while disabled");

   ready_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
      (cpu_ready && clk_en) |=> !cpu_ready)
      else $error("access ready longer than one cycle");

   write_resp_a: assert property (@(posedge clk_sys) disable iff (rst)
      (wr_go && clk_en) |=> s_axi_bvalid)
      else $error("write answer late");

endmodule

// file: cpu_core_model.sv
// CPU core model issuing one memory access at a time
module cpu_core_model
   import internal_periph_bus_decoder_pkg::*;
(
   input  wire logic       clk_sys,
   output cpu_req_t        cpu_req,
   output logic            cpu_req_valid,
   input  wire logic       cpu_ready,
   input  wire logic [6:0] tgt_sel,
   input  wire cpu_req_t   tgt_req
);
   initial begin
      cpu_req = '0;
      cpu_req_valid = 1'b0;
   end

   // Whole byte or word moves only, never single-bit operations
   task automatic access(input logic [23:0] a, input logic [1:0] be,
                         output logic [6:0] sel, output cpu_req_t seen, output int lat);
      sel = '0;
      seen = '0;
      lat = 0;
      @(posedge clk_sys);
      cpu_req <= '{addr: a, write: a[1], byte_en: be, wdata: {a[7:0], ~a[7:0]}};
      cpu_req_valid <= 1'b1;
      forever begin
         @(negedge clk_sys);
         lat++;
         if (tgt_sel !== 7'h00) begin
            sel = tgt_sel;
            seen = tgt_req;
         end
         if (cpu_ready === 1'b1) break;
      end
      @(posedge clk_sys);
      cpu_req_valid <= 1'b0;
      // Released lines show the inverse so a stale request never looks current
      cpu_req <= ~cpu_req;
   endtask
endmodule

// file: onchip_internal_periph_bus_address_decoder_tb.sv
// Self-checking bench for the address decoder
module onchip_internal_periph_bus_address_decoder_tb import internal_periph_bus_decoder_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys, rst, clk_en;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   cpu_req_t    cpu_req, tgt_req;
   logic        cpu_req_valid, cpu_ready, seg_limit;
   logic [6:0]  tgt_sel;
   int          err_total, tests_run, cycles;

   always #10 clk_sys = ~clk_sys;

   internal_periph_bus_address_decoder dut (.clk_sys, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cpu_req, .cpu_req_valid, .cpu_ready, .tgt_req, .tgt_sel, .seg_limit);
   cpu_core_model cpu (.clk_sys, .cpu_req, .cpu_req_valid, .cpu_ready, .tgt_sel, .tgt_req);

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // A hang costs one mismatch and ends the run through the same report
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ra, rw, ta, tw;
      ta = 0;
      tw = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge clk_sys);
         ra = s_axi_awvalid & s_axi_awready;
         rw = s_axi_wvalid & s_axi_wready;
         @(posedge clk_sys);
         if (ra) s_axi_awvalid <= 1'b0;
         if (rw) s_axi_wvalid <= 1'b0;
         ta = ta | ra;
         tw = tw | rw;
      end
      do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask

   // Word access on odd words (a[1] set), byte access otherwise
   task automatic route(input logic [23:0] a, input target_t t, output int lat);
      logic [6:0] sel;
      cpu_req_t   seen;
      logic [1:0] be;
      be = a[1] ? 2'b11 : 2'b01;
      cpu.access(a, be, sel, seen, lat);
      check(32'(sel), 32'(7'h01 << t), "target select");
      check(32'(seen.addr), 32'(a), "address at target");
      check(32'(seen.byte_en), 32'(be), "byte lanes at target");
      check(32'(seen.write), 32'(a[1]), "write flag at target");
      check(32'(seen.wdata), 32'({a[7:0], ~a[7:0]}), "write data at target");
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_after_reset();
      logic [31:0] d;
      logic [1:0]  r;
      int          l;
      axi_read(PERCFG_OFS, d, r);
      check(d, 32'(PERCFG_RESET), "peripheral config reset");
      axi_read(SYSCFG_OFS, d, r);
      check(d, 32'h0, "system config reset");
      axi_read(8'h0c, d, r);
      check(32'(r), 32'(RESP_SLVERR), "unmapped read");
      axi_write(8'h10, 32'hff, r);
      check(32'(r), 32'(RESP_SLVERR), "unmapped write");
      route(SMALL_RAM_LO, TGT_EXT, l);
      route(LARGE_RAM_HI, TGT_EXT, l);
      route(FIRST_CAN_MODULE_LO, TGT_EXT, l);
      route(SECOND_CAN_MODULE_HI, TGT_EXT, l);
      check(32'(seg_limit), 32'h0, "segment limit off");
   endtask

   task automatic t_all_on_and_lock();
      logic [23:0] a [14] = '{SMALL_RAM_LO, SMALL_RAM_HI, LARGE_RAM_LO, LARGE_RAM_HI,
         FIRST_CAN_MODULE_LO, FIRST_CAN_MODULE_HI, SECOND_CAN_MODULE_LO, SECOND_CAN_MODULE_HI, 24'h00e800, 24'h00bfff, INTERNAL_DUAL_PORT_RAM_LO,
         STD_FUNC_LO, EXT_FUNC_HI, 24'hffffff};
      target_t     t [14] = '{TGT_SMALL_RAM, TGT_SMALL_RAM, TGT_LARGE_RAM, TGT_LARGE_RAM,
         TGT_FIRST_CAN_MODULE, TGT_FIRST_CAN_MODULE, TGT_SECOND_CAN_MODULE, TGT_SECOND_CAN_MODULE, TGT_EXT, TGT_EXT, TGT_INTERNAL_DUAL_PORT_RAM,
         TGT_FUNC, TGT_FUNC, TGT_EXT};
      logic [31:0] d;
      logic [1:0]  r;
      int          l_ram, l_can;
      axi_write(PERCFG_OFS, 32'h0f, r);
      axi_write(SYSCFG_OFS, 32'h04, r);
      for (int i = 0; i < 14; i++) route(a[i], t[i], l_ram);
      check(32'(seg_limit), 32'h1, "segment limit on");
      axi_read(STATUS_OFS, d, r);
      check(d, 32'h20, "status idle with CAN");
      route(SMALL_RAM_HI, TGT_SMALL_RAM, l_ram);
      route(SECOND_CAN_MODULE_LO, TGT_SECOND_CAN_MODULE, l_can);
      // The CAN access adds exactly two wait states over the RAM access
      check(32'(l_can - l_ram), 32'h2, "CAN wait states");
      axi_write(PERCFG_OFS, 32'h00, r);
      check(32'(r), 32'(RESP_OKAY), "locked write response");
      axi_read(PERCFG_OFS, d, r);
      check(d, 32'h0f, "locked config kept");
      route(LARGE_RAM_LO, TGT_LARGE_RAM, l_ram);
   endtask

   task automatic t_large_only();
      logic [1:0] r;
      int         l;
      axi_write(SYSCFG_OFS, 32'h00, r);
      axi_write(PERCFG_OFS, 32'h08, r);
      axi_write(SYSCFG_OFS, 32'h04, r);
      route(LARGE_RAM_LO, TGT_LARGE_RAM, l);
      route(SMALL_RAM_LO, TGT_EXT, l);
      route(SECOND_CAN_MODULE_LO, TGT_EXT, l);
      route(FIRST_CAN_MODULE_HI, TGT_EXT, l);
      check(32'(seg_limit), 32'h0, "segment limit without CAN");
      axi_write(SYSCFG_OFS, 32'h00, r);
      route(LARGE_RAM_HI, TGT_EXT, l);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {clk_sys, err_total, tests_run, cycles} = '0;
      rst = 1'b1;
      clk_en = 1'b1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_after_reset();
      t_all_on_and_lock();
      t_large_only();
      finish_test();
   end
endmodule
